// ==== verilog/paged_rom_autoboot_sequencer.sv ====
// What this block does
// - Two-page image uses one page line
// - In reset, select upper code page
// - Hold autoboot request low until reset rises
// - Drive autoboot request open-drain only
// - Wait 175 ms after reset release
// - Mask interrupt input during download wait
// - Verify boot by comparing variable to default
// - On mismatch wait 5 ms, read again
// - Second mismatch restarts boot from reset
// - Four 64K pages chosen by two bits
// - Table application boots from page two
// - Page to table region before launch
// - Configuration at launch, after table page set for table app
`timescale 1ns/1ns
`default_nettype none

module paged_rom_autoboot_sequencer #(
  parameter int unsigned DL_WAIT_CYC = autoboot_pkg::DOWNLOAD_WAIT_CYC,
  parameter int unsigned RETRY_CYC = autoboot_pkg::RETRY_WAIT_CYC,
  parameter int unsigned HOLD_CYC = autoboot_pkg::RESET_HOLD_CYC,
  parameter logic [15:0] VERIFY_VALUE = autoboot_pkg::VERIFY_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Boot command
  input wire logic start_i,
  input wire logic table_app_i,
  // Variable read port toward the serial engine
  output logic read_req_o,
  input wire logic read_valid_i,
  input wire logic [15:0] read_data_i,
  // Launch handshake toward the message engine
  output logic launch_req_o,
  input wire logic launch_done_i,
  // Decoder pins
  output logic decoder_reset_n_o,
  input wire logic autoboot_request_n_i,
  output logic autoboot_request_n_o,
  output logic autoboot_request_n_oe_o,
  output logic host_page_select_lo_o,
  output logic host_page_select_hi_o,
  // Host side
  output logic interrupt_request_o,
  output logic config_enable_o,
  output logic booted_o,
  output logic [7:0] restart_count_o
);

  localparam int unsigned TW = 28;

  autoboot_pkg::boot_state_t state_ff;
  autoboot_pkg::boot_state_t nxt_state;
  autoboot_pkg::boot_pins_t pins_ff;
  autoboot_pkg::boot_pins_t nxt_pins;
  autoboot_pkg::read_rsp_t rsp;
  logic table_ff;
  logic read_req_ff;
  logic launch_ff;
  logic cfg_ff;
  logic booted_ff;
  logic irq_ff;
  logic [7:0] restarts_ff;
  logic [1:0] irq_sync_ff;
  logic timer_load;
  logic [TW-1:0] timer_count;
  logic timer_done;
  logic timer_busy;

  assign rsp.valid = read_valid_i;
  assign rsp.data = read_data_i;

  // Code page for the chosen application
  function automatic logic [1:0] boot_page(input logic table_app);
    boot_page = table_app ? autoboot_pkg::PAGE_TABLE_APP
                          : autoboot_pkg::PAGE_SIMPLE_BOOT;
  endfunction : boot_page

  wire match_w = rsp.valid && (rsp.data == VERIFY_VALUE);
  wire miss_w = rsp.valid && (rsp.data != VERIFY_VALUE);
  wire [1:0] code_page_w = boot_page(table_ff);
  wire dl_masked_w = (state_ff == autoboot_pkg::ST_RESET) ||
                     (state_ff == autoboot_pkg::ST_DL_WAIT);

  wait_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .done_o(timer_done),
    .busy_o(timer_busy)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    timer_load = 1'b0;
    timer_count = '0;
    case (state_ff)
      autoboot_pkg::ST_IDLE: begin
        if (start_i) begin
          nxt_state = autoboot_pkg::ST_RESET;
          nxt_pins.reset_n = 1'b0;
          nxt_pins.autoboot_request_n_oe = 1'b1;
          nxt_pins.page = boot_page(table_app_i);
          timer_load = 1'b1;
          timer_count = TW'(HOLD_CYC);
        end
      end
      autoboot_pkg::ST_RESET: begin
        nxt_pins.page = code_page_w;
        if (timer_done) begin
          // Request stays low across the reset rising edge
          nxt_pins.reset_n = 1'b1;
          nxt_state = autoboot_pkg::ST_DL_WAIT;
          timer_load = 1'b1;
          timer_count = TW'(DL_WAIT_CYC);
        end
      end
      autoboot_pkg::ST_DL_WAIT: begin
        // Let go so the decoder can own the shared pin
        nxt_pins.autoboot_request_n_oe = 1'b0;
        if (timer_done) begin
          nxt_state = autoboot_pkg::ST_READ1;
        end
      end
      autoboot_pkg::ST_READ1: begin
        if (match_w) begin
          nxt_state = table_ff ? autoboot_pkg::ST_TABLE_PAGE
                               : autoboot_pkg::ST_LAUNCH;
        end else if (miss_w) begin
          nxt_state = autoboot_pkg::ST_RETRY_WAIT;
          timer_load = 1'b1;
          timer_count = TW'(RETRY_CYC);
        end
      end
      autoboot_pkg::ST_RETRY_WAIT: begin
        if (timer_done) begin
          nxt_state = autoboot_pkg::ST_READ2;
        end
      end
      autoboot_pkg::ST_READ2: begin
        if (match_w) begin
          nxt_state = table_ff ? autoboot_pkg::ST_TABLE_PAGE
                               : autoboot_pkg::ST_LAUNCH;
        end else if (miss_w) begin
          nxt_state = autoboot_pkg::ST_RESET;
          nxt_pins.reset_n = 1'b0;
          nxt_pins.autoboot_request_n_oe = 1'b1;
          timer_load = 1'b1;
          timer_count = TW'(HOLD_CYC);
        end
      end
      autoboot_pkg::ST_TABLE_PAGE: begin
        // Decoder reads tables at run time from this page
        nxt_pins.page = autoboot_pkg::PAGE_TABLE_DATA;
        nxt_state = autoboot_pkg::ST_LAUNCH;
      end
      autoboot_pkg::ST_LAUNCH: begin
        if (launch_done_i) begin
          nxt_state = autoboot_pkg::ST_READY;
        end
      end
      autoboot_pkg::ST_READY: begin
        if (start_i) begin
          nxt_state = autoboot_pkg::ST_RESET;
          nxt_pins.reset_n = 1'b0;
          nxt_pins.autoboot_request_n_oe = 1'b1;
          nxt_pins.page = boot_page(table_app_i);
          timer_load = 1'b1;
          timer_count = TW'(HOLD_CYC);
        end
      end
      default: begin
        nxt_state = autoboot_pkg::ST_IDLE;
      end
    endcase
  end

  wire leave_ready_w = (state_ff == autoboot_pkg::ST_IDLE ||
                        state_ff == autoboot_pkg::ST_READY) && start_i;
  wire is_read_w = (nxt_state == autoboot_pkg::ST_READ1) ||
                   (nxt_state == autoboot_pkg::ST_READ2);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_ff <= autoboot_pkg::ST_IDLE;
      pins_ff <= '{reset_n: 1'b0, autoboot_request_n_oe: 1'b0, page: 2'h0};
      table_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      table_ff <= leave_ready_w ? table_app_i : table_ff;
    end
  end

  // Read request stands until the answer arrives
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      read_req_ff <= 1'b0;
      launch_ff <= 1'b0;
      cfg_ff <= 1'b0;
      booted_ff <= 1'b0;
    end else begin
      read_req_ff <= is_read_w && !rsp.valid;
      launch_ff <= (nxt_state == autoboot_pkg::ST_LAUNCH) && !launch_done_i;
      // Configuration only while in launch, dropped at ready; for the table app the table page is already on the lines
      cfg_ff <= nxt_state == autoboot_pkg::ST_LAUNCH;
      booted_ff <= nxt_state == autoboot_pkg::ST_READY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      restarts_ff <= 8'h00;
    end else if (state_ff == autoboot_pkg::ST_READ2 && miss_w) begin
      restarts_ff <= restarts_ff + 8'h01;
    end
  end

  // Shared pin is asynchronous to this clock
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_sync_ff <= 2'h3;
      irq_ff <= 1'b0;
    end else begin
      irq_sync_ff <= {irq_sync_ff[0], autoboot_request_n_i};
      irq_ff <= !irq_sync_ff[1] && !dl_masked_w &&
                !pins_ff.autoboot_request_n_oe;
    end
  end

  assign decoder_reset_n_o = pins_ff.reset_n;
  assign autoboot_request_n_o = 1'b0;
  assign autoboot_request_n_oe_o = pins_ff.autoboot_request_n_oe;
  assign host_page_select_lo_o = pins_ff.page[0];
  assign host_page_select_hi_o = pins_ff.page[1];
  assign read_req_o = read_req_ff;
  assign launch_req_o = launch_ff;
  assign config_enable_o = cfg_ff;
  assign booted_o = booted_ff;
  assign interrupt_request_o = irq_ff;
  assign restart_count_o = restarts_ff;

  property p_req_low_at_release;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(pins_ff.reset_n) |-> pins_ff.autoboot_request_n_oe;
  endproperty
  a_req_low_at_release: assert property (p_req_low_at_release)
    else $error("request released before reset rose");

  property p_page_stable;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_DL_WAIT) |-> $stable(pins_ff.page);
  endproperty
  a_page_stable: assert property (p_page_stable)
    else $error("page moved during download wait");

  property p_dl_timer_runs;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_DL_WAIT) |-> (timer_busy || timer_done);
  endproperty
  a_dl_timer_runs: assert property (p_dl_timer_runs)
    else $error("download wait left without timer");

  property p_irq_masked;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_DL_WAIT) |=> !irq_ff;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt passed during download wait");

  property p_table_before_launch;
    @(posedge clk_i) disable iff (!nrst_i)
      (cfg_ff && table_ff) |-> (pins_ff.page == 2'h3);
  endproperty
  a_table_before_launch: assert property (p_table_before_launch)
    else $error("launch without table page");

  property p_retry_reset;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_READ2 && miss_w) |=> !pins_ff.reset_n;
  endproperty
  a_retry_reset: assert property (p_retry_reset)
    else $error("second mismatch did not restart");

  property p_first_miss_waits;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_READ1 && miss_w) |=>
        (state_ff == autoboot_pkg::ST_RETRY_WAIT) [*2];
  endproperty
  a_first_miss_waits: assert property (p_first_miss_waits)
    else $error("no retry wait after first mismatch");

  property p_match_goes_on;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_READ1 && match_w) |=> booted_ff == 1'b0
        && (state_ff != autoboot_pkg::ST_RETRY_WAIT);
  endproperty
  a_match_goes_on: assert property (p_match_goes_on)
    else $error("match treated as failure");

  property p_reset_page;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == autoboot_pkg::ST_RESET && !table_ff) |->
        pins_ff.page == 2'h1;
  endproperty
  a_reset_page: assert property (p_reset_page)
    else $error("wrong code page in reset");

endmodule : paged_rom_autoboot_sequencer

`default_nettype wire

// ==== verilog/autoboot_pkg.sv ====
package autoboot_pkg;

  // Timebase
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned DOWNLOAD_WAIT_MS = 175;
  localparam int unsigned RETRY_WAIT_MS = 5;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned DOWNLOAD_WAIT_CYC = DOWNLOAD_WAIT_MS * CYC_PER_MS;
  localparam int unsigned RETRY_WAIT_CYC = RETRY_WAIT_MS * CYC_PER_MS;
  // Decoder reset hold, starting as page and request are set
  localparam int unsigned RESET_HOLD_CYC = 16;

  // Address layout
  localparam int unsigned LOW_ADDR_BITS = 16;
  localparam int unsigned PAGE_BITS = 2;
  localparam logic [19:0] TABLE_REGION_ADDR = 20'h30000;

  // Page codes {hi, lo}
  localparam logic [1:0] PAGE_SIMPLE_BOOT = 2'h1;
  localparam logic [1:0] PAGE_TABLE_APP = 2'h2;
  localparam logic [1:0] PAGE_TABLE_DATA =
    TABLE_REGION_ADDR[LOW_ADDR_BITS +: PAGE_BITS];

  // Variable read default
  localparam int unsigned VAR_WIDTH = 16;
  localparam logic [15:0] VERIFY_DEFAULT = 16'hA55A;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RESET = 4'h1,
    ST_DL_WAIT = 4'h2,
    ST_READ1 = 4'h3,
    ST_RETRY_WAIT = 4'h4,
    ST_READ2 = 4'h5,
    ST_TABLE_PAGE = 4'h6,
    ST_LAUNCH = 4'h7,
    ST_READY = 4'h8
  } boot_state_t;

  // Variable read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } read_rsp_t;

  // Pins toward the decoder and ROM
  typedef struct packed {
    logic reset_n;
    logic autoboot_request_n_oe;
    logic [1:0] page;
  } boot_pins_t;

endpackage : autoboot_pkg

// ==== verilog/wait_timer.sv ====
`timescale 1ns/1ns
`default_nettype none

// Down-counter: load starts it, done pulses once when it reaches zero
module wait_timer #(
  parameter int unsigned WIDTH = 28
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  // Status
  output logic done_o,
  output logic busy_o
);

  logic [WIDTH-1:0] cnt_ff;
  logic run_ff;
  logic done_ff;
  wire last_w = run_ff && (cnt_ff == '0);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (load_i) begin
      cnt_ff <= count_i;
      run_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= last_w ? cnt_ff : cnt_ff - 1'b1;
      run_ff <= run_ff && !last_w;
      done_ff <= last_w;
    end
  end

  assign done_o = done_ff;
  assign busy_o = run_ff;

endmodule : wait_timer

`default_nettype wire

// ==== verif/decoder_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Decoder plus paged boot ROM as the host sees them
module decoder_model #(
  parameter logic [15:0] VERIFY = autoboot_pkg::VERIFY_DEFAULT
) (
  // Clock and test control
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] bad_reads_i,
  input wire logic irq_cmd_i,
  // Pins from the host
  input wire logic reset_n_i,
  input wire logic pin_n_i,
  input wire logic [1:0] page_i,
  // Host engines
  input wire logic read_req_i,
  output logic read_valid_o,
  output logic [15:0] read_data_o,
  input wire logic launch_req_i,
  output logic launch_done_o,
  // Model status
  output logic irq_drive_o,
  output logic [1:0] run_page_o,
  output logic [17:0] rom_addr_o
);
  logic rst_q_ff;
  logic loaded_ff;
  logic [2:0] bad_ff;
  logic [1:0] dly_ff;
  logic [15:0] low_addr_ff;
  logic busy;

  assign rom_addr_o = {page_i, low_addr_ff};
  assign irq_drive_o = loaded_ff & reset_n_i & irq_cmd_i;
  assign busy = (read_req_i & ~read_valid_o) | (launch_req_i & ~launch_done_o);

  always_ff @(posedge clk_i) begin
    rst_q_ff <= reset_n_i;
    low_addr_ff <= low_addr_ff + 16'h0001;
    read_valid_o <= 1'b0;
    launch_done_o <= 1'b0;
    read_data_o <= ~read_data_o;
    dly_ff <= busy ? dly_ff + 2'h1 : 2'h0;
    if (!reset_n_i) begin
      loaded_ff <= 1'b0;
    end else if (!rst_q_ff && !pin_n_i) begin
      loaded_ff <= 1'b1;
    end
    if (busy && dly_ff == 2'h2) begin
      dly_ff <= 2'h0;
      read_valid_o <= read_req_i;
      launch_done_o <= launch_req_i;
      // Table decoding keeps reading the page set at launch
      if (launch_req_i) begin
        run_page_o <= page_i;
      end
      if (read_req_i) begin
        read_data_o <= (loaded_ff && bad_ff == 3'h0) ? VERIFY : ~VERIFY;
        if (bad_ff != 3'h0) begin
          bad_ff <= bad_ff - 3'h1;
        end
      end
    end
    if (!nrst_i) begin
      bad_ff <= bad_reads_i;
      low_addr_ff <= 16'h0000;
      dly_ff <= 2'h0;
      run_page_o <= 2'h0;
      read_data_o <= 16'h0000;
    end
  end
endmodule : decoder_model

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam int unsigned DLW = 40;
  localparam int unsigned RTY = 10;
  logic clk_i, nrst_i, start_i, table_app_i, read_valid_i, launch_done_i;
  logic [15:0] read_data_i;
  logic read_req_o, launch_req_o, decoder_reset_n_o, pin_n, autoboot_request_n_n_o;
  logic autoboot_request_n_oe, page_lo, page_hi, interrupt_request_o, config_enable_o;
  logic booted_o, irq_drive, irq_cmd, prev_rst, prev_req, after_rst, in_wait;
  logic [7:0] restart_count_o;
  logic [2:0] bad_reads;
  logic [1:0] run_page, boot_page, exp_final;
  logic [31:0] seed;
  int bad_count, checks, evt_cyc, reads;
  int cyc = 0;
  logic [1:0] pg;
  int unsigned gap;

  // Shared pin has a pull-up
  assign pin_n = !((autoboot_request_n_oe && !autoboot_request_n_n_o) || irq_drive);
  assign pg = {page_hi, page_lo};
  assign gap = after_rst ? DLW : RTY;

  paged_rom_autoboot_sequencer #(.DL_WAIT_CYC(DLW), .RETRY_CYC(RTY))
  u_paged_rom_autoboot_sequencer (
    .clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i),
    .table_app_i(table_app_i), .read_req_o(read_req_o),
    .read_valid_i(read_valid_i), .read_data_i(read_data_i),
    .launch_req_o(launch_req_o), .launch_done_i(launch_done_i),
    .decoder_reset_n_o(decoder_reset_n_o), .autoboot_request_n_i(pin_n),
    .autoboot_request_n_o(autoboot_request_n_n_o), .autoboot_request_n_oe_o(autoboot_request_n_oe),
    .host_page_select_lo_o(page_lo), .host_page_select_hi_o(page_hi),
    .interrupt_request_o(interrupt_request_o),
    .config_enable_o(config_enable_o), .booted_o(booted_o),
    .restart_count_o(restart_count_o));

  decoder_model u_decoder_model (
    .clk_i(clk_i), .nrst_i(nrst_i), .bad_reads_i(bad_reads),
    .irq_cmd_i(irq_cmd), .reset_n_i(decoder_reset_n_o), .pin_n_i(pin_n),
    .page_i({page_hi, page_lo}), .read_req_i(read_req_o),
    .read_valid_o(read_valid_i), .read_data_o(read_data_i),
    .launch_req_i(launch_req_o), .launch_done_o(launch_done_i),
    .irq_drive_o(irq_drive), .run_page_o(run_page), .rom_addr_o());

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [1:0] exp_page(input logic t, input logic fin);
    if (!t) return autoboot_pkg::PAGE_SIMPLE_BOOT;
    return fin ? autoboot_pkg::PAGE_TABLE_DATA : autoboot_pkg::PAGE_TABLE_APP;
  endfunction : exp_page

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic tally_and_finish;
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Pin and timing watcher
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    prev_rst <= decoder_reset_n_o;
    prev_req <= read_req_o;
    if (!nrst_i) begin
      in_wait <= 1'b0;
      after_rst <= 1'b0;
      reads <= 0;
      evt_cyc <= cyc;
    end else begin
      if (autoboot_request_n_oe) check_val(16'(autoboot_request_n_n_o), 16'h0000);
      if (!decoder_reset_n_o) in_wait <= 1'b1;
      if (decoder_reset_n_o && !prev_rst) begin
        check_val(16'(pin_n), 16'h0000);
        check_val(16'(pg), 16'(exp_page(table_app_i, 1'b0)));
        boot_page <= pg;
        after_rst <= 1'b1;
        evt_cyc <= cyc;
      end
      if (in_wait) check_val(16'(interrupt_request_o), 16'h0000);
      if (read_req_o && !prev_req) begin
        check_val(16'(cyc - evt_cyc >= gap), 16'h0001);
        in_wait <= 1'b0;
        after_rst <= 1'b0;
      end
      if (read_req_o) check_val(16'(pg), 16'(boot_page));
      if (read_valid_i) begin
        reads <= reads + 1;
        evt_cyc <= cyc;
      end
      if (config_enable_o) check_val(16'(pg), 16'(exp_final));
    end
  end

  // Warm runs restart from the ready state without a bench reset
  task automatic run(input logic t, input logic [2:0] b, input logic warm);
    int n;
    int r0;
    logic [7:0] c0;
    table_app_i = t;
    bad_reads = b;
    exp_final = exp_page(t, 1'b1);
    if (!warm) begin
      nrst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
    end
    @(negedge clk_i);
    r0 = reads;
    c0 = restart_count_o;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    n = 0;
    while (decoder_reset_n_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    // Device activity during the download must stay hidden
    irq_cmd = 1'b1;
    repeat (DLW / 2) @(negedge clk_i);
    irq_cmd = 1'b0;
    n = 0;
    while (booted_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check_val(16'(booted_o), 16'h0001);
    check_val(16'(reads - r0), 16'(b + 3'h1));
    check_val(16'(restart_count_o - c0), 16'(b / 3'h2));
    check_val(16'(pg), 16'(exp_final));
    check_val(16'(run_page), 16'(exp_final));
    irq_cmd = 1'b1;
    repeat (5) @(negedge clk_i);
    check_val(16'(interrupt_request_o), 16'h0001);
    irq_cmd = 1'b0;
    repeat (5) @(negedge clk_i);
    check_val(16'(interrupt_request_o), 16'h0000);
  endtask : run

  initial begin
    nrst_i = 1'b0;
    start_i = 1'b0;
    table_app_i = 1'b0;
    bad_reads = 3'h0;
    irq_cmd = 1'b0;
    bad_count = 0;
    checks = 0;
    seed = 32'h16480E7E;
    repeat (12) @(negedge clk_i);
    for (int i = 0; i < 8; i++) run(i[0], 3'(i >> 1), 1'b0);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      run(seed[0], 3'(seed[5:4]), 1'b0);
      run(seed[1], 3'h0, 1'b1);
    end
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
